// >>> core/cacc_map.svh
/*
  Register offsets, reset values and widths of the counter array
  capture/compare block, as `define macros.
  Assumes it is included by bare name by the package and the top.
*/
// Function
// (R1) every module mode register resets to zero, all functions off
// (R2) wide select: clear gives 8-bit modulation, set gives 16-bit
// (R3) rising or falling pin edge captures counter, enables independent
// (R4) match enable sets module flag when counter equals module value
// (R5) toggle inverts pin on each match; with modulation gives frequency out
// (R6) modulation enable drives pin with counter-derived duty waveform
// (R7) flag requests interrupt only when module interrupt enable is one
// (R8) counter bits 7 to 0 are a read/write byte register
// (R9) counter bits 15 to 8 are a separate read/write byte register
// (R10) per module, a read/write byte holds value bits 7 to 0
// (R11) per module, a read/write byte holds value bits 15 to 8
// (R12) comparator enable gates match, toggle and modulation behaviour
// (R13) capture writes both value bytes in one clock cycle
`ifndef CACC_MAP_SVH
`define CACC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CACC_MODE0_ADDR 8'hDA
`define CACC_MODE1_ADDR 8'hDB
`define CACC_MODE2_ADDR 8'hDC
`define CACC_MODE3_ADDR 8'hDD
`define CACC_MODE4_ADDR 8'hDE
`define CACC_VLO0_ADDR 8'hFB
`define CACC_VHI0_ADDR 8'hFC
`define CACC_VLO1_ADDR 8'hE9
`define CACC_VHI1_ADDR 8'hEA
`define CACC_VLO2_ADDR 8'hEB
`define CACC_VHI2_ADDR 8'hEC
`define CACC_VLO3_ADDR 8'hED
`define CACC_VHI3_ADDR 8'hEE
`define CACC_VLO4_ADDR 8'hFD
`define CACC_VHI4_ADDR 8'hFE
`define CACC_CNT_LO_ADDR 8'hF9
`define CACC_CNT_HI_ADDR 8'hFA

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define CACC_MODE_RST 8'h00
`define CACC_VALUE_RST 16'h0000
`define CACC_CNT_RST 16'h0000
`define CACC_RDATA_IDLE 8'h00
`define CACC_MAX_MODULES 5

`endif

// >>> core/cacc_pkg.sv
/*
  Types of the counter array capture/compare block.
  Assumes cacc_map.svh sits beside it on the include path.
*/
`include "cacc_map.svh"

package cacc_pkg;

  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic wide_modulation_select;
    logic comparator_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_flag_enable;
    logic pin_invert_enable;
    logic pulse_width_enable;
    logic module_irq_enable;
  } cacc_mode_type;

  // one special function register access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cacc_sfr_req_type;

endpackage

// >>> core/cacc_top.sv
/*
  Counter array capture/compare: one shared 16-bit counter and up to
  five capture/compare modules reached as special function registers.
  Assumes the core drives sfr_req_i and count_tick_i on clk_i, that
  module flags are cleared by the control logic outside, and that the
  module pins arrive asynchronously.
*/
`timescale 1ns/1ps
`include "cacc_map.svh"

module cacc_top #(
  parameter int NUM_MODULES = `CACC_MAX_MODULES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire cacc_pkg::cacc_sfr_req_type sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic count_tick_i,
  input wire logic [NUM_MODULES-1:0] flag_clear_i,
  input wire logic [NUM_MODULES-1:0] module_pin_i,
  output logic [NUM_MODULES-1:0] module_pin_o,
  output logic [NUM_MODULES-1:0] module_pin_oe_o,
  output logic [NUM_MODULES-1:0] module_event_flag_o,
  output logic module_irq_o
);
  import cacc_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // only five modules have addresses; more cannot be reached
  generate
    if (NUM_MODULES < 1 || NUM_MODULES > `CACC_MAX_MODULES) begin : g_bad
      $error("cacc_top: NUM_MODULES must be 1 to 5");
    end
  endgenerate

  // ----------------------------------------------------------------
  // address tables
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_ADDR [`CACC_MAX_MODULES] = '{
    `CACC_MODE0_ADDR, `CACC_MODE1_ADDR, `CACC_MODE2_ADDR,
    `CACC_MODE3_ADDR, `CACC_MODE4_ADDR
  };
  localparam logic [7:0] VLO_ADDR [`CACC_MAX_MODULES] = '{
    `CACC_VLO0_ADDR, `CACC_VLO1_ADDR, `CACC_VLO2_ADDR,
    `CACC_VLO3_ADDR, `CACC_VLO4_ADDR
  };
  localparam logic [7:0] VHI_ADDR [`CACC_MAX_MODULES] = '{
    `CACC_VHI0_ADDR, `CACC_VHI1_ADDR, `CACC_VHI2_ADDR,
    `CACC_VHI3_ADDR, `CACC_VHI4_ADDR
  };

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] cnt_r;
  logic cnt_moved_r;
  cacc_mode_type mode_r [NUM_MODULES];
  logic [15:0] value_r [NUM_MODULES];
  logic [NUM_MODULES-1:0] pin_s1_r;
  logic [NUM_MODULES-1:0] pin_s2_r;
  logic [NUM_MODULES-1:0] pin_s3_r;
  logic [NUM_MODULES-1:0] flag_r;
  logic [NUM_MODULES-1:0] pin_r;
  logic [NUM_MODULES-1:0] pin_oe_r;
  logic [NUM_MODULES-1:0] flag_set;
  logic irq_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic cnt_lo_wr;
  logic cnt_hi_wr;

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  // byte strobes for the two counter registers
  assign cnt_lo_wr = sfr_req_i.wr &&
                     sfr_req_i.addr == `CACC_CNT_LO_ADDR;
  assign cnt_hi_wr = sfr_req_i.wr &&
                     sfr_req_i.addr == `CACC_CNT_HI_ADDR;

  // software write wins over a tick in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= `CACC_CNT_RST;
    end else if (ce_i) begin
      if (cnt_lo_wr) begin
        cnt_r[7:0] <= sfr_req_i.wdata; // [R8]
      end else if (cnt_hi_wr) begin
        cnt_r[15:8] <= sfr_req_i.wdata; // [R9]
      end else if (count_tick_i) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // match is judged once per new counter value, not per clock,
  // so a stopped counter does not keep firing the same match
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_moved_r <= 1'b0;
    end else if (ce_i) begin
      cnt_moved_r <= count_tick_i | cnt_lo_wr | cnt_hi_wr;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // third stage is only the previous level for edge detection
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else if (ce_i) begin
      pin_s1_r <= module_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // capture/compare modules
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : g_mod
      cacc_mode_type mode;
      logic rise;
      logic fall;
      logic capture;
      logic freq_mode;
      logic hit;
      logic match;
      logic pwm_level;
      logic mode_wr;
      logic vlo_wr;
      logic vhi_wr;

      assign mode = mode_r[g];
      assign mode_wr = sfr_req_i.wr && sfr_req_i.addr == MODE_ADDR[g];
      assign vlo_wr = sfr_req_i.wr && sfr_req_i.addr == VLO_ADDR[g];
      assign vhi_wr = sfr_req_i.wr && sfr_req_i.addr == VHI_ADDR[g];

      // edge enables act independently of each other
      assign rise = pin_s2_r[g] & ~pin_s3_r[g];
      assign fall = ~pin_s2_r[g] & pin_s3_r[g];
      assign capture = (rise & mode.rise_capture_enable) |
                       (fall & mode.fall_capture_enable); // [R3]

      // frequency output compares the low byte only
      assign freq_mode = mode.pin_invert_enable &
                         mode.pulse_width_enable; // [R5] [R6]
      assign hit = freq_mode ? cnt_r[7:0] == value_r[g][7:0] :
                               cnt_r == value_r[g];
      assign match = mode.comparator_enable & cnt_moved_r &
                     hit; // [R12]

      // duty cycle from the low byte or the full word
      assign pwm_level = mode.wide_modulation_select ?
                         cnt_r >= value_r[g] :
                         cnt_r[7:0] >= value_r[g][7:0]; // [R2]

      // mode register
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          mode_r[g] <= `CACC_MODE_RST; // [R1]
        end else if (ce_i && mode_wr) begin
          mode_r[g] <= cacc_mode_type'(sfr_req_i.wdata);
        end
      end

      // value register; capture beats a software write
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          value_r[g] <= `CACC_VALUE_RST;
        end else if (ce_i) begin
          if (capture) begin
            value_r[g] <= cnt_r; // [R13]
          end else if (vlo_wr) begin
            value_r[g][7:0] <= sfr_req_i.wdata; // [R10]
          end else if (vhi_wr) begin
            value_r[g][15:8] <= sfr_req_i.wdata; // [R11]
          end else if (freq_mode && match) begin
            // next toggle point is half a period further on
            value_r[g][7:0] <= value_r[g][7:0] + value_r[g][15:8];
          end
        end
      end

      // flag sources: capture, or match with match enable
      assign flag_set[g] = capture |
                           (match & mode.match_flag_enable); // [R4]

      // flag is sticky; a new event beats a clear
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          flag_r[g] <= 1'b0;
        end else if (ce_i) begin
          if (flag_set[g]) begin
            flag_r[g] <= 1'b1;
          end else if (flag_clear_i[g]) begin
            flag_r[g] <= 1'b0;
          end
        end
      end

      // pin output; held level when no output mode is active
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pin_r[g] <= 1'b0;
        end else if (ce_i && mode.comparator_enable) begin // [R12]
          if (freq_mode || (mode.pin_invert_enable &&
              !mode.pulse_width_enable)) begin
            if (match) begin
              pin_r[g] <= ~pin_r[g]; // [R5]
            end
          end else if (mode.pulse_width_enable) begin
            pin_r[g] <= pwm_level; // [R6]
          end
        end
      end

      // pin is driven only while an output mode owns it
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pin_oe_r[g] <= 1'b0;
        end else if (ce_i) begin
          pin_oe_r[g] <= mode.comparator_enable &
                         (mode.pin_invert_enable |
                          mode.pulse_width_enable);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // only flags whose module enable is set may request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= 1'b0;
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (flag_r[i] && mode_r[i].module_irq_enable) begin
          irq_r <= 1'b1; // [R7]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    rdata_nxt = `CACC_RDATA_IDLE;
    if (sfr_req_i.addr == `CACC_CNT_LO_ADDR) begin
      rdata_nxt = cnt_r[7:0]; // [R8]
    end
    if (sfr_req_i.addr == `CACC_CNT_HI_ADDR) begin
      rdata_nxt = cnt_r[15:8]; // [R9]
    end
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (sfr_req_i.addr == MODE_ADDR[i]) begin
        rdata_nxt = mode_r[i];
      end
      if (sfr_req_i.addr == VLO_ADDR[i]) begin
        rdata_nxt = value_r[i][7:0]; // [R10]
      end
      if (sfr_req_i.addr == VHI_ADDR[i]) begin
        rdata_nxt = value_r[i][15:8]; // [R11]
      end
    end
  end

  // registered read: data follows the address by one clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= `CACC_RDATA_IDLE;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_o = rdata_r;
  assign module_pin_o = pin_r;
  assign module_pin_oe_o = pin_oe_r;
  assign module_event_flag_o = flag_r;
  assign module_irq_o = irq_r;

endmodule

// >>> dv/cacc_monitor.sv
/*
  Port-level checker for cacc_top.
  Assumes it is bound to cacc_top and sees only its ports.
*/
`timescale 1ns/1ps

module cacc_monitor #(
  parameter int NUM_MODULES = 5
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire cacc_pkg::cacc_sfr_req_type sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [NUM_MODULES-1:0] flag_clear_i,
  input wire logic [NUM_MODULES-1:0] module_pin_i,
  input wire logic [NUM_MODULES-1:0] module_pin_o,
  input wire logic [NUM_MODULES-1:0] module_pin_oe_o,
  input wire logic [NUM_MODULES-1:0] module_event_flag_o,
  input wire logic module_irq_o
);
  import cacc_pkg::*;
  // ----------------------------------------------
  // shadow of the mode registers, from bus writes
  // ----------------------------------------------
  cacc_mode_type mode_r [NUM_MODULES];
  logic [NUM_MODULES-1:0] oe_exp, irq_en;
  logic [7:0] idx, rd_mode;
  logic is_mode, is_cnt, is_val, irq_exp;
  // index out of range only when is_mode is low
  assign idx = sfr_req_i.addr - 8'hDA;
  assign is_mode = int'(idx) < NUM_MODULES;
  assign rd_mode = is_mode ? mode_r[idx[2:0]] : 8'h00;
  assign is_cnt = sfr_req_i.addr inside {8'hF9, 8'hFA};
  assign is_val = sfr_req_i.addr inside {[8'hE9:8'hEE], [8'hFB:8'hFE]};
  assign irq_exp = |(module_event_flag_o & irq_en);
  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mode
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        mode_r[i] <= '0;
      end else if (ce_i && sfr_req_i.wr && int'(idx) == i) begin
        mode_r[i] <= sfr_req_i.wdata;
      end
    end
    assign oe_exp[i] = mode_r[i].comparator_enable &
      (mode_r[i].pin_invert_enable | mode_r[i].pulse_width_enable);
    assign irq_en[i] = mode_r[i].module_irq_enable;
  end
  // ----------------------------------------------
  // assertions
  // ----------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_RST_ZERO: assert property (
    $fell(reset_i) |-> !(|{module_pin_o, module_pin_oe_o,
      module_event_flag_o, module_irq_o, sfr_rdata_o}))
    else $error("outputs not cleared by reset");
  AST_RD_MODE: assert property (
    ce_i && !sfr_req_i.wr && is_mode |=> sfr_rdata_o == $past(rd_mode))
    else $error("mode readback wrong");
  AST_OE_GATE: assert property (
    !$past(reset_i) |-> module_pin_oe_o == $past(oe_exp))
    else $error("pin enable disagrees with mode");
  AST_IRQ_MASK: assert property (
    !$past(reset_i) |-> module_irq_o == $past(irq_exp))
    else $error("interrupt request wrong");
  AST_FLAG_HOLD: assert property (
    ce_i && module_event_flag_o[0] && !flag_clear_i[0]
      |=> module_event_flag_o[0])
    else $error("flag dropped without clear");
  AST_CNT_RW: assert property (
    (ce_i && sfr_req_i.wr && is_cnt) ##1 (ce_i && !sfr_req_i.wr &&
      sfr_req_i.addr == $past(sfr_req_i.addr))
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("counter byte readback wrong");
  AST_VAL_RW: assert property (
    (ce_i && sfr_req_i.wr && is_val) ##1 (ce_i && !sfr_req_i.wr &&
      sfr_req_i.addr == $past(sfr_req_i.addr))
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("value byte readback wrong");
  AST_CAPT_FLAG: assert property (
    ce_i && (mode_r[0].rise_capture_enable && $rose(module_pin_i[0]) ||
      mode_r[0].fall_capture_enable && $fell(module_pin_i[0]))
      |-> ##[1:6] module_event_flag_o[0])
    else $error("capture edge set no flag");
endmodule

bind cacc_top cacc_monitor #(.NUM_MODULES(NUM_MODULES)) mon_u (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .flag_clear_i(flag_clear_i),
  .module_pin_i(module_pin_i), .module_pin_o(module_pin_o),
  .module_pin_oe_o(module_pin_oe_o),
  .module_event_flag_o(module_event_flag_o), .module_irq_o(module_irq_o));

// >>> dv/cacc_top_tb.sv
/*
  Self-checking bench of cacc_top: registers, capture, match, modulation.
  Assumes the bench alone drives every port, changing inputs at negedge.
*/
`timescale 1ns/1ps

module cacc_top_tb;
  import cacc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  cacc_sfr_req_type req = '0;
  logic [7:0] rdata, d;
  logic tick = 1'b0;
  logic [4:0] fclr = '0, pin = '0, pin_o, oe, flag;
  logic irq, p0, ce = 1'b1;
  logic [15:0] cv;
  int err_count = 0, samples_checked = 0, cyc = 0, seed = 12;
  logic [7:0] addrs [17] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hE9,
    8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hF9, 8'hFA, 8'hFB, 8'hFC,
    8'hFD, 8'hFE};
  // clock enable is driven so the freeze path gets exercised too
  cacc_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .count_tick_i(tick),
    .flag_clear_i(fclr), .module_pin_i(pin), .module_pin_o(pin_o),
    .module_pin_oe_o(oe), .module_event_flag_o(flag),
    .module_irq_o(irq));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    req = '{1'b1, a, v};
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req = '{1'b0, a, 8'h00};
    @(negedge clk_i);
    chk("sfr_rdata_o", 16'(e), 16'(rdata));
  endtask
  task automatic cnt(input logic [15:0] v);
    wr(8'hF9, v[7:0]);
    wr(8'hFA, v[15:8]);
  endtask
  task automatic wait_flag();
    for (int k = 0; k < 10 && flag[0] !== 1'b1; k++) @(negedge clk_i);
  endtask
  task automatic clear_flag();
    fclr[0] = 1'b1;
    @(negedge clk_i);
    fclr[0] = 1'b0;
  endtask
  // modulation level from the counter, narrow or wide compare
  function automatic logic pwm_exp(input logic w, input logic [15:0] c);
    return w ? (c >= 16'h1280) : (c[7:0] >= 8'h80);
  endfunction
  task automatic final_report();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 5; i++) rc(addrs[i], 8'h00);
    rc(8'h00, 8'h00);
    for (int i = 0; i < 17; i++) begin
      d = 8'($random(seed));
      wr(addrs[i], d);
      rc(addrs[i], d);
      if (i < 5) wr(addrs[i], 8'h00);
    end
    // low byte carry into high byte
    cnt(16'h12FF);
    tick = 1'b1;
    @(negedge clk_i);
    tick = 1'b0;
    rc(8'hFA, 8'h13);
    rc(8'hF9, 8'h00);
    // rise capture with interrupt, then fall capture without
    cv = 16'($random(seed));
    cnt(cv);
    wr(8'hDA, 8'h21);
    wr(8'hDE, 8'h20);
    pin = 5'h11;
    wait_flag();
    chk("flag rise", 16'h1, 16'(flag[0]));
    chk("flag4 rise", 16'h1, 16'(flag[4]));
    rc(8'hFD, cv[7:0]);
    rc(8'hFB, cv[7:0]);
    rc(8'hFC, cv[15:8]);
    chk("irq", 16'h1, 16'(irq));
    clear_flag();
    cv = ~cv;
    cnt(cv);
    wr(8'hDA, 8'h10);
    pin[0] = 1'b0;
    wait_flag();
    rc(8'hFC, cv[15:8]);
    chk("irq masked", 16'h0, 16'(irq));
    clear_flag();
    cnt(16'h0F0F);
    pin[0] = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("flag fall only", 16'h0, 16'(flag[0]));
    rc(8'hFB, cv[7:0]);
    // match: comparator off, then on
    wr(8'hDA, 8'h00);
    wr(8'hFB, 8'h00);
    wr(8'hFC, 8'h01);
    for (int m = 0; m < 2; m++) begin
      cnt(16'h00FC);
      wr(8'hDA, m ? 8'h4C : 8'h0C);
      p0 = pin_o[0];
      tick = 1'b1;
      repeat (8) @(negedge clk_i);
      tick = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("match flag", 16'(m), 16'(flag[0]));
      chk("toggle", 16'(p0 ^ m[0]), 16'(pin_o[0]));
      clear_flag();
    end
    // modulation, narrow and wide, random counter values
    wr(8'hFB, 8'h80);
    wr(8'hFC, 8'h12);
    for (int i = 0; i < 8; i++) begin
      cv = 16'($random(seed));
      wr(8'hDA, {i[0], 7'h42});
      cnt(cv);
      repeat (3) @(negedge clk_i);
      chk("pwm pin", 16'(pwm_exp(i[0], cv)), 16'(pin_o[0]));
    end
    // frequency output: low byte match toggles, low byte steps by high
    wr(8'hDA, 8'h00);
    wr(8'hFB, 8'h10);
    wr(8'hFC, 8'h08);
    cnt(16'h0000);
    wr(8'hDA, 8'h46);
    p0 = pin_o[0];
    tick = 1'b1;
    repeat (20) @(negedge clk_i);
    tick = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("freq pin", 16'(!p0), 16'(pin_o[0]));
    rc(8'hFB, 8'h18);
    // frozen clock enable: tick and write are both ignored
    ce = 1'b0;
    tick = 1'b1;
    wr(8'hF9, 8'hAA);
    tick = 1'b0;
    ce = 1'b1;
    rc(8'hF9, 8'h14);
    final_report();
  end
endmodule
